// [cmp_ctrl_defines.svh]
// register offsets, field positions, reset values and timing counts
// included by the comparator control module and the bench
`ifndef CMP_CTRL_DEFINES_SVH
`define CMP_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (32-bit aligned words)
// ----------------------------------------------------------------
`define CMP_OFS_CTRL0      8'h00
`define CMP_OFS_CTRL1      8'h04
`define CMP_OFS_IRQ_STAT   8'h08
`define CMP_OFS_IRQ_EN     8'h0C
`define CMP_OFS_IRQ_CLR    8'h10
`define CMP_OFS_PIN_CFG    8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CMP_BIT_ENABLE     7
`define CMP_BIT_OUT_STATE  6
`define CMP_BIT_RISE_FLAG  5
`define CMP_BIT_FALL_FLAG  4
`define CMP_POS_HYS_HI     3
`define CMP_POS_HYS_LO     2
`define CMP_NEG_HYS_HI     1
`define CMP_NEG_HYS_LO     0
`define CMP_CTRL_RESET     8'h00

// ----------------------------------------------------------------
// pin routing fields: per channel route bit and push-pull bit
// ----------------------------------------------------------------
`define CMP_BIT_ROUTE0     0
`define CMP_BIT_PUSHPULL0  1
`define CMP_BIT_ROUTE1     2
`define CMP_BIT_PUSHPULL1  3
`define CMP_BIT_RST_SRC    4

// ----------------------------------------------------------------
// timing: settling time after enable, in microseconds
// ----------------------------------------------------------------
`define CMP_SETTLE_US      20000
`define CMP_CLK_MHZ        125

`endif

// [cmp_ctrl_pkg.sv]
// types shared by the comparator control block
// assumes cmp_ctrl_defines.svh is on the include path
package cmp_ctrl_pkg;

   // hysteresis setting codes
   typedef enum logic [1:0] {
      HYS_OFF,
      HYS_2MV,
      HYS_4MV,
      HYS_10MV
   } hys_sel_t;

   typedef logic [1:0] hys_pair_t;

endpackage

// [cmp_ctrl.sv]
// dual comparator control and status logic, wishbone slave
// assumes asynchronous comparator outputs from analog cores and a port
// pin mux outside that turns out/oe into the pin level
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cmp_ctrl_defines.svh"

module cmp_ctrl #(
   parameter int SETTLE_CYCLES = `CMP_SETTLE_US * `CMP_CLK_MHZ
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     clk_en_in,
   // wishbone classic slave
   input  wire logic                     wb_cyc_in,
   input  wire logic                     wb_stb_in,
   input  wire logic                     wb_we_in,
   input  wire logic [7:0]               wb_adr_in,
   input  wire logic [31:0]              wb_dat_in,
   input  wire logic [3:0]               wb_sel_in,
   output logic      [31:0]              wb_dat_out,
   output logic                          wb_ack_out,
   // analog cores
   input  wire logic [1:0]               cmp_raw_in,
   output logic      [1:0]               cmp_power_out,
   output cmp_ctrl_pkg::hys_pair_t       cmp0_pos_hys_out,
   output cmp_ctrl_pkg::hys_pair_t       cmp0_neg_hys_out,
   output cmp_ctrl_pkg::hys_pair_t       cmp1_pos_hys_out,
   output cmp_ctrl_pkg::hys_pair_t       cmp1_neg_hys_out,
   // port 1 pins
   output logic      [1:0]               pin_out,
   output logic      [1:0]               pin_oe_out,
   // system
   output logic      [1:0]               cmp_settled_out,
   output logic                          cmp_reset_req_out,
   output logic                          irq_out
);
   import cmp_ctrl_pkg::*;

   // the settle counter is 24 bits wide
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 32'h00FF_FFFF) begin : g_chk
      $error("SETTLE_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]       sync1;
      logic [1:0]       sync2;
      logic [1:0]       prev;
      logic [1:0]       en;
      logic [1:0][3:0]  hys;
      logic [1:0]       rise;
      logic [1:0]       fall;
      logic [3:0]       irq_en;
      logic [4:0]       pin_cfg;
      logic [1:0][23:0] settle;
      logic [1:0]       settled;
      logic [1:0]       pin;
      logic [1:0]       pin_oe;
      logic             rst_req;
      logic             irq;
      logic             ack;
      logic [31:0]      dat;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic        req;
   logic        wr;
   logic [1:0]  live;
   logic [1:0]  rise_ev;
   logic [1:0]  fall_ev;
   logic [3:0]  stat;
   logic [31:0] rdata;

   always_comb begin
      state_next = state_reg;
      req = wb_cyc_in && wb_stb_in && !state_reg.ack;
      wr = req && wb_we_in && wb_sel_in[0];
      // first stage feeds only the second stage
      state_next.sync1 = cmp_raw_in;
      state_next.sync2 = state_reg.sync1;
      // a disabled core reads low, so it makes no edges
      live = state_reg.sync2 & state_reg.en;
      state_next.prev = live;
      rise_ev = live & ~state_reg.prev;
      fall_ev = ~live & state_reg.prev & state_reg.en;

      // ----------------------------------------------------------------
      // register reads
      // ----------------------------------------------------------------
      stat = {state_reg.fall, state_reg.rise};
      unique case (wb_adr_in)
         `CMP_OFS_CTRL0, `CMP_OFS_CTRL1: begin
            rdata = {24'h00_0000,
                     state_reg.en[wb_adr_in[2]],
                     live[wb_adr_in[2]],
                     state_reg.rise[wb_adr_in[2]],
                     state_reg.fall[wb_adr_in[2]],
                     state_reg.hys[wb_adr_in[2]]};
         end
         `CMP_OFS_IRQ_STAT: rdata = {28'h000_0000, stat};
         `CMP_OFS_IRQ_EN:   rdata = {28'h000_0000, state_reg.irq_en};
         `CMP_OFS_PIN_CFG:  rdata = {27'h000_0000, state_reg.pin_cfg};
         default:           rdata = 32'h0000_0000;
      endcase
      state_next.ack = req;
      if (req) begin
         state_next.dat = rdata;
      end

      // ----------------------------------------------------------------
      // register writes and flags; hardware set beats software clear
      // ----------------------------------------------------------------
      for (int i = 0; i < 2; i++) begin
         if (wr && wb_adr_in == (i == 0 ? `CMP_OFS_CTRL0 : `CMP_OFS_CTRL1))
         begin
            state_next.en[i] = wb_dat_in[`CMP_BIT_ENABLE];
            state_next.hys[i] = wb_dat_in[3:0];
            // writing 0 clears a flag, writing 1 leaves it
            if (!wb_dat_in[`CMP_BIT_RISE_FLAG]) begin
               state_next.rise[i] = 1'b0;
            end
            if (!wb_dat_in[`CMP_BIT_FALL_FLAG]) begin
               state_next.fall[i] = 1'b0;
            end
         end
         if (wr && wb_adr_in == `CMP_OFS_IRQ_CLR) begin
            if (wb_dat_in[i]) begin
               state_next.rise[i] = 1'b0;
            end
            if (wb_dat_in[i + 2]) begin
               state_next.fall[i] = 1'b0;
            end
         end
         if (rise_ev[i]) begin
            state_next.rise[i] = 1'b1;
         end
         if (fall_ev[i]) begin
            state_next.fall[i] = 1'b1;
         end
         // settle counter restarts on every enable; settled also gates the reset request
         if (!state_next.en[i]) begin
            state_next.settle[i] = 24'h00_0000;
            state_next.settled[i] = 1'b0;
         end else if (state_reg.settle[i] != SETTLE_CYCLES[23:0]) begin
            state_next.settle[i] = state_reg.settle[i] + 24'h00_0001;
         end else begin
            state_next.settled[i] = 1'b1;
         end
      end
      if (wr && wb_adr_in == `CMP_OFS_IRQ_EN) begin
         state_next.irq_en = wb_dat_in[3:0];
      end
      if (wr && wb_adr_in == `CMP_OFS_PIN_CFG) begin
         state_next.pin_cfg = wb_dat_in[4:0];
      end

      // ----------------------------------------------------------------
      // pins, reset request and interrupt
      // ----------------------------------------------------------------
      for (int i = 0; i < 2; i++) begin
         if (state_reg.pin_cfg[2 * i]) begin
            // push-pull drives both levels, open drain only pulls low
            // open drain never drives high, the pull-up does
            state_next.pin[i] = live[i] &&
                                state_reg.pin_cfg[2 * i + 1];
            state_next.pin_oe[i] = state_reg.pin_cfg[2 * i + 1] || !live[i];
         end else begin
            state_next.pin[i] = 1'b0;
            state_next.pin_oe[i] = 1'b0;
         end
      end
      // reset request when the reset source bit is set and comparator 0 is enabled, settled and low
      state_next.rst_req = state_reg.pin_cfg[`CMP_BIT_RST_SRC] &&
                           state_reg.en[0] && state_reg.settled[0] &&
                           !live[0];
      // interrupts gated by enable so a shut core cannot interrupt
      state_next.irq = |(state_next.rise & state_next.en &
                         state_reg.irq_en[1:0]) ||
                       |(state_next.fall & state_next.en &
                         state_reg.irq_en[3:2]);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   assign wb_dat_out        = state_reg.dat;
   assign wb_ack_out        = state_reg.ack;
   assign cmp_power_out     = state_reg.en;
   assign cmp0_pos_hys_out  = state_reg.hys[0][3:2];
   assign cmp0_neg_hys_out  = state_reg.hys[0][1:0];
   assign cmp1_pos_hys_out  = state_reg.hys[1][3:2];
   assign cmp1_neg_hys_out  = state_reg.hys[1][1:0];
   assign pin_out           = state_reg.pin;
   assign pin_oe_out        = state_reg.pin_oe;
   assign cmp_settled_out   = state_reg.settled;
   assign cmp_reset_req_out = state_reg.rst_req;
   assign irq_out           = state_reg.irq;

endmodule

// [cmp_core_model.sv]
// behavioural pair of analog comparator cores
// assumes the bench sets the level each core resolves
`timescale 1ns/1ps
module cmp_core_model (
   input  wire logic [1:0] power_in,
   input  wire logic [1:0] level_in,
   output logic      [1:0] raw_out
);
   // a core in shutdown resolves nothing and idles low
   assign raw_out = power_in & level_in;
endmodule

// [cmp_ctrl_sva.sv]
// port checker for the comparator control block
// assumes one clock domain and the bench setting clk_en_in high
`timescale 1ns/1ps
module cmp_ctrl_sva (
   input wire logic                   clk_in,
   input wire logic                   rst_n_in,
   input wire logic                   clk_en_in,
   input wire logic                   wb_cyc_in,
   input wire logic                   wb_stb_in,
   input wire logic                   wb_ack_out,
   input wire logic [1:0]             cmp_power_out,
   input wire cmp_ctrl_pkg::hys_pair_t cmp0_pos_hys_out,
   input wire cmp_ctrl_pkg::hys_pair_t cmp0_neg_hys_out,
   input wire logic [1:0]             cmp_settled_out,
   input wire logic                   cmp_reset_req_out,
   input wire logic [1:0]             pin_out,
   input wire logic [1:0]             pin_oe_out
);
   import cmp_ctrl_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out && clk_en_in;
   endsequence
   sequence s_off;
      !cmp_power_out[0] [*4];
   endsequence
   property p_ack; s_req |=> wb_ack_out ##1 !wb_ack_out; endproperty
   property p_ack_cause;
      $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
   endproperty
   // configuration only moves around an acknowledged access
   property p_cfg;
      $changed({cmp0_pos_hys_out, cmp0_neg_hys_out, cmp_power_out})
         |-> wb_ack_out || $past(wb_ack_out);
   endproperty
   property p_settle_pwr; cmp_settled_out[0] |-> cmp_power_out[0];
   endproperty
   property p_settle_wait;
      $rose(cmp_power_out[0]) |-> !cmp_settled_out[0] [*8];
   endproperty
   property p_rst_req;
      cmp_reset_req_out |-> cmp_power_out[0] && cmp_settled_out[0];
   endproperty
   property p_pin_off; s_off |-> !pin_out[0]; endproperty
   property p_pin_drv; pin_out[0] |-> pin_oe_out[0]; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   a_cfg: assert property (p_cfg) else $error("config moved");
   a_settle_pwr: assert property (p_settle_pwr) else $error("settled off");
   a_settle_wait: assert property (p_settle_wait) else $error("early");
   a_rst_req: assert property (p_rst_req) else $error("reset req");
   a_pin_off: assert property (p_pin_off) else $error("pin high");
   a_pin_drv: assert property (p_pin_drv) else $error("pin undriven");
endmodule
bind cmp_ctrl cmp_ctrl_sva i_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .clk_en_in(clk_en_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_ack_out(wb_ack_out), .cmp_power_out(cmp_power_out),
   .cmp0_pos_hys_out(cmp0_pos_hys_out), .cmp0_neg_hys_out(cmp0_neg_hys_out),
   .cmp_settled_out(cmp_settled_out), .cmp_reset_req_out(cmp_reset_req_out),
   .pin_out(pin_out), .pin_oe_out(pin_oe_out));

// [tb.sv]
// self-checking bench for the comparator control block
// assumes the core model and checker are compiled alongside
`timescale 1ns/1ps
`include "cmp_ctrl_defines.svh"
module tb;
   import cmp_ctrl_pkg::*;
   logic        clk_in, rst_n_in, cyc, we, ack, irq, rreq;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, rd;
   logic [1:0]  lvl, raw, pwr, pin, oe, setl;
   hys_pair_t   p0, n0, p1, n1;
   int          fail_count, tests_run;
   cmp_ctrl #(.SETTLE_CYCLES(20)) i_dut (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .clk_en_in(1'b1), .wb_cyc_in(cyc),
      .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_sel_in(4'h1), .wb_dat_out(rdat), .wb_ack_out(ack),
      .cmp_raw_in(raw), .cmp_power_out(pwr), .cmp0_pos_hys_out(p0),
      .cmp0_neg_hys_out(n0), .cmp1_pos_hys_out(p1), .cmp1_neg_hys_out(n1),
      .pin_out(pin), .pin_oe_out(oe), .cmp_settled_out(setl),
      .cmp_reset_req_out(rreq), .irq_out(irq));
   cmp_core_model i_core (.power_in(pwr), .level_in(lvl), .raw_out(raw));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle; stb shares the cyc wire
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         fail_count++;
         end_of_test;
      end
      rd = rdat;
      cyc <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
      bus(a, 1'b0, 32'h0);
      chk(nm, rd, e);
   endtask
   task automatic waitc(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   task automatic settle(input int ch);
      int n;
      n = 0;
      while (setl[ch] !== 1'b1 && n < 80) begin
         @(posedge clk_in);
         n++;
      end
      chk("settled", setl[ch], 1);
   endtask
   task automatic t_reset;
      logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
      foreach (offs[i]) rdc(offs[i], 0, "reset value");
      wr(8'h18, 32'hFF);
      rdc(8'h18, 0, "unmapped");
      $display("reset test done");
   endtask
   task automatic t_hys;
      for (int i = 0; i < 4; i++) begin
         wr(`CMP_OFS_CTRL0, 32'h80 | (i << 2) | (3 - i));
         wr(`CMP_OFS_CTRL1, i);
         chk("hys0 pos", p0, hys_sel_t'(i));
         chk("hys0 neg", n0, 3 - i);
         chk("hys1 neg", n1, i);
         chk("power", pwr, 2'b01);
      end
      wr(`CMP_OFS_CTRL1, 32'h8C);
      chk("hys1 pos", p1, HYS_10MV);
      chk("power both", pwr, 2'b11);
      wr(`CMP_OFS_CTRL0, 0);
      wr(`CMP_OFS_CTRL1, 0);
      chk("power off", pwr, 2'b00);
      $display("hysteresis test done");
   endtask
   task automatic t_edges;
      logic [7:0] a;
      for (int ch = 0; ch < 2; ch++) begin
         a = ch ? `CMP_OFS_CTRL1 : `CMP_OFS_CTRL0;
         wr(`CMP_OFS_IRQ_EN, 32'hF);
         wr(a, 32'h80);
         settle(ch);
         lvl[ch] <= 1'b1;
         waitc(6);
         rdc(a, 32'hE0, "rise state");
         chk("irq", irq, 1);
         rdc(`CMP_OFS_IRQ_STAT, 32'h1 << ch, "status");
         wr(`CMP_OFS_IRQ_EN, 0);
         chk("irq mask", irq, 0);
         lvl[ch] <= 1'b0;
         waitc(6);
         rdc(a, 32'hB0, "both flags");
         wr(`CMP_OFS_IRQ_CLR, 32'h5 << ch);
         rdc(`CMP_OFS_IRQ_STAT, 0, "cleared");
         wr(a, 0);
         lvl[ch] <= 1'b1;
         waitc(6);
         rdc(`CMP_OFS_IRQ_STAT, 0, "off edge");
         lvl[ch] <= 1'b0;
      end
      $display("edge test done");
   endtask
   task automatic t_pins;
      wr(`CMP_OFS_PIN_CFG, 32'h3);
      wr(`CMP_OFS_CTRL0, 32'h80);
      lvl[0] <= 1'b1;
      waitc(6);
      chk("push pull", {oe[0], pin[0]}, 2'b11);
      wr(`CMP_OFS_CTRL0, 0);
      waitc(4);
      chk("pin off", pin[0], 0);
      wr(`CMP_OFS_PIN_CFG, 32'h1);
      wr(`CMP_OFS_CTRL0, 32'h80);
      waitc(6);
      chk("drain high", {oe[0], pin[0]}, 2'b00);
      lvl[0] <= 1'b0;
      waitc(6);
      chk("drain low", {oe[0], pin[0]}, 2'b10);
      $display("pin test done");
   endtask
   task automatic t_rst_src;
      wr(`CMP_OFS_PIN_CFG, 32'h10);
      settle(0);
      waitc(4);
      chk("reset req", rreq, 1);
      lvl[0] <= 1'b1;
      waitc(6);
      chk("no req high", rreq, 0);
      wr(`CMP_OFS_CTRL0, 0);
      wr(`CMP_OFS_CTRL1, 32'h80);
      settle(1);
      waitc(4);
      chk("no req cmp1", rreq, 0);
      $display("reset source test done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      end_of_test;
   end
   initial begin
      rst_n_in = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      lvl = 2'b00;
      fail_count = 0;
      tests_run = 0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset;
      t_hys;
      t_edges;
      t_pins;
      t_rst_src;
      end_of_test;
   end
endmodule
